// [design/pgf_consts.svh]
`ifndef PGF_CONSTS_SVH
`define PGF_CONSTS_SVH

// ****************************************************************
// Register byte offsets on the APB
// ****************************************************************
`define PGF_OFS_DIR        8'h00
`define PGF_OFS_UPPER      8'h04
`define PGF_OFS_LOWER      8'h08
`define PGF_OFS_CKO        8'h0C

// ****************************************************************
// Reset values and writable-bit masks (reserved bits hold 1)
// ****************************************************************
`define PGF_RST_DIR        16'h0000
`define PGF_RST_UPPER      16'h0AAA
`define PGF_RST_LOWER      16'hAA80
`define PGF_RST_CKO        16'hFFFE
`define PGF_WMASK_DIR      16'hFFFF
`define PGF_WMASK_UPPER    16'hF555
`define PGF_WMASK_LOWER    16'h557F
`define PGF_WMASK_CKO      16'h0001

// ****************************************************************
// Field positions (least significant bit of each field)
// ****************************************************************
`define PGF_U_PIN15        14
`define PGF_U_PIN14        12
`define PGF_U_TMR_BASE     2
`define PGF_U_TMR_STEP     2
`define PGF_U_PIN8         0
`define PGF_L_PIN7         14
`define PGF_L_PIN6         12
`define PGF_L_PIN5         10
`define PGF_L_PIN4         8
`define PGF_L_PIN3         6
`define PGF_L_PIN2         5
`define PGF_L_PIN1         4
`define PGF_L_PIN0         2
`define PGF_L_IRQMD        0
`define PGF_CKO_LOW        0

// ****************************************************************
// Pin numbers and timer channel indices
// ****************************************************************
`define PGF_PIN_TMR_BASE   9
`define PGF_TMR_SINGLE     5
`define PGF_TMR_A5         5
`define PGF_TMR_B5         6

// ****************************************************************
// Field codes
// ****************************************************************
`define PGF_CODE_ALT1      2'b01
`define PGF_CODE_ALT2      2'b10
`define PGF_IRQM_HIGH      2'b00
`define PGF_IRQM_REQ       2'b01

`endif

// [design/pgf_pkg.sv]
package pgf_pkg;

  // ****************************************************************
  // Shared types
  // ****************************************************************
  typedef logic [15:0] pgf_word_t;
  typedef logic [1:0]  pgf_code_t;
  typedef logic [6:0]  pgf_tmr_t;

endpackage : pgf_pkg

// [design/pgf_sync2.sv]
`timescale 1ns/1ns

// ****************************************************************
// Two-stage synchroniser for pin-level inputs
// ****************************************************************
module pgf_sync2
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pgf_sync2

// [design/pgf_pin_mux.sv]
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "pgf_consts.svh"

// Overview of operation
// [RULE_01] 16-bit direction register, one bit per pin
// [RULE_02] Direction bit steers GPIO, serial clock, timer
// [RULE_03] Other functions ignore the direction bit
// [RULE_04] Direction clears on reset and hardware standby
// [RULE_05] Mode registers reset to 0AAA and AA80
// [RULE_06] Upper register: pins 15-8; lower: 7-0
// [RULE_07] Pin 15: GPIO, interrupt five, timer B5
// [RULE_08] Pin 14: GPIO, interrupt four, timer A5
// [RULE_09] Single bits select timers on pins 13-9
// [RULE_10] Upper bit 0 routes serial2 receive
// [RULE_11] Lower bits 14,12,10 select serial data
// [RULE_12] Lower bits 8,4 select serial clocks
// [RULE_13] Lower bits 6,5 select serial0 data
// [RULE_14] Pin 0: GPIO, ADC trigger, interrupt output
// [RULE_15] Interrupt output mode: high or controller-driven
// [RULE_16] Reserved bits always read as one
// [RULE_17] Clock pin: internal clock, or forced low; code outputs a half-rate copy
// [RULE_18] Clock control resets to FFFE
// [RULE_19] Reserved codes leave the pin as GPIO
module pgf_pin_mux
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Reset and standby sources
  input  wire logic              hw_standby,
  input  wire logic              wdt_por,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Package pins
  input  wire pgf_pkg::pgf_word_t pin_in,
  output pgf_pkg::pgf_word_t     pin_out,
  output pgf_pkg::pgf_word_t     pin_oe_n,
  output logic                   clock_pin_out,
  // General I/O side
  input  wire pgf_pkg::pgf_word_t gpio_out,
  output pgf_pkg::pgf_word_t     gpio_in,
  // External interrupt inputs
  output logic                   ext_interrupt_five,
  output logic                   ext_interrupt_four,
  // Timer channels, index 0 = D3 up to 6 = B5
  input  wire pgf_pkg::pgf_tmr_t timer_chan_out,
  output pgf_pkg::pgf_tmr_t      timer_chan_in,
  // Serial channels
  output logic                   serial2_receive,
  input  wire logic              serial2_transmit,
  output logic                   serial1_receive,
  input  wire logic              serial1_transmit,
  input  wire logic              serial1_clock_out,
  output logic                   serial1_clock_in,
  output logic                   serial0_receive,
  input  wire logic              serial0_transmit,
  input  wire logic              serial0_clock_out,
  output logic                   serial0_clock_in,
  // A/D trigger and interrupt request
  output logic                   adc_trigger_input,
  input  wire logic              interrupt_controller_req
);
  import pgf_pkg::*;

  // ****************************************************************
  // Pin and standby synchronisation
  // ****************************************************************
  pgf_word_t pin_s;
  logic      hwstby_s;

  // Pins and standby share one two-flop stage
  pgf_sync2 #(
    .WIDTH    (17)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({hw_standby, pin_in}),
    .sync_out ({hwstby_s, pin_s})
  );

  // ****************************************************************
  // Register file
  // ****************************************************************
  pgf_word_t dir_q;
  pgf_word_t upper_q;
  pgf_word_t lower_q;
  pgf_word_t cko_q;
  logic      access;
  logic      wr_en;
  logic      hit;
  pgf_word_t rd_mux;

  // Byte-lane merge; reserved bits are forced back to one
  function automatic pgf_word_t merge(pgf_word_t old_v,
                                      pgf_word_t wmask);
    pgf_word_t be;
    be = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    merge = (((old_v & ~be) | (pwdata[15:0] & be)) & wmask)
            | ~wmask; // RULE_16
  endfunction : merge

  // Second access cycle is the one where pready is seen high
  assign access = psel & penable & ~pready;
  assign wr_en  = psel & penable & pready & pwrite & ~hwstby_s;

  // Address decode and read mux
  always_comb
  begin
    hit    = 1'b1;
    rd_mux = '0;
    unique case (paddr)
      `PGF_OFS_DIR:   rd_mux = dir_q;
      `PGF_OFS_UPPER: rd_mux = upper_q; // RULE_16
      `PGF_OFS_LOWER: rd_mux = lower_q; // RULE_16
      `PGF_OFS_CKO:   rd_mux = cko_q;   // RULE_16
      default:        hit    = 1'b0;
    endcase
  end

  // Direction register; standby acts like power-on reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      dir_q <= `PGF_RST_DIR; // RULE_04
    else if (hwstby_s)
      dir_q <= `PGF_RST_DIR; // RULE_04
    else if (wr_en && paddr == `PGF_OFS_DIR)
      dir_q <= merge(dir_q, `PGF_WMASK_DIR); // RULE_01
  end

  // Upper mode register; watchdog reset leaves it alone
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      upper_q <= `PGF_RST_UPPER; // RULE_05
    else if (hwstby_s)
      upper_q <= `PGF_RST_UPPER; // RULE_05
    else if (wr_en && paddr == `PGF_OFS_UPPER)
      upper_q <= merge(upper_q, `PGF_WMASK_UPPER); // RULE_06
  end

  // Lower mode register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      lower_q <= `PGF_RST_LOWER; // RULE_05
    else if (hwstby_s)
      lower_q <= `PGF_RST_LOWER; // RULE_05
    else if (wr_en && paddr == `PGF_OFS_LOWER)
      lower_q <= merge(lower_q, `PGF_WMASK_LOWER); // RULE_06
  end

  // Clock control also follows the watchdog power-on reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cko_q <= `PGF_RST_CKO; // RULE_18
    else if (hwstby_s || wdt_por)
      cko_q <= `PGF_RST_CKO; // RULE_18
    else if (wr_en && paddr == `PGF_OFS_CKO)
      cko_q <= merge(cko_q, `PGF_WMASK_CKO);
  end

  // APB answer: one wait state, data and error with pready
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= access;
      pslverr <= access & ~hit;
      prdata  <= (access && !pwrite) ? {16'h0000, rd_mux} : '0;
    end
  end

  // ****************************************************************
  // Function decode
  // ****************************************************************
  pgf_code_t code15;
  pgf_code_t code14;
  pgf_code_t code0;
  pgf_code_t irq_mode;
  pgf_tmr_t  tmr_en;
  pgf_word_t alt_sel;  // Pin owned by a peripheral
  pgf_word_t alt_free; // Peripheral fixes the direction
  pgf_word_t alt_drv;  // Fixed-direction function drives
  pgf_word_t alt_dat;  // Peripheral output level
  logic      ext_interrupt_five_en;
  logic      ext_interrupt_four_en;
  logic      adc_en;
  logic      irq_level;

  assign code15   = upper_q[`PGF_U_PIN15 +: 2];
  assign code14   = upper_q[`PGF_U_PIN14 +: 2];
  assign code0    = lower_q[`PGF_L_PIN0 +: 2];
  assign irq_mode = lower_q[`PGF_L_IRQMD +: 2];

  // Interrupt output level, active low on request
  always_comb
  begin
    case (irq_mode)
      `PGF_IRQM_HIGH: irq_level = 1'b1;                      // RULE_15
      `PGF_IRQM_REQ:  irq_level = ~interrupt_controller_req; // RULE_15
      default:        irq_level = 1'b1;                      // RULE_19
    endcase
  end

  // Per-pin routing; reserved codes fall through to GPIO
  always_comb
  begin
    alt_sel  = '0;
    alt_free = '0;
    alt_drv  = '0;
    alt_dat  = '0;
    tmr_en   = '0;
    ext_interrupt_five_en  = 1'b0;
    ext_interrupt_four_en  = 1'b0;
    adc_en   = 1'b0;
    // Top pin
    case (code15)
      `PGF_CODE_ALT1: ext_interrupt_five_en              = 1'b1; // RULE_07
      `PGF_CODE_ALT2: tmr_en[`PGF_TMR_B5]  = 1'b1; // RULE_07
      default:        ;                            // RULE_19
    endcase
    // Pin 14
    case (code14)
      `PGF_CODE_ALT1: ext_interrupt_four_en              = 1'b1; // RULE_08
      `PGF_CODE_ALT2: tmr_en[`PGF_TMR_A5]  = 1'b1; // RULE_08
      default:        ;                            // RULE_19
    endcase
    // Single-bit timer pins 13 down to 9
    for (int k = 0; k < `PGF_TMR_SINGLE; k++)
      tmr_en[k] = upper_q[`PGF_U_TMR_BASE
                          + `PGF_U_TMR_STEP * k]; // RULE_09
    // Timers keep the direction bit
    for (int k = 0; k < 7; k++)
      if (tmr_en[k])
      begin
        alt_sel[`PGF_PIN_TMR_BASE + k] = 1'b1;            // RULE_02
        alt_dat[`PGF_PIN_TMR_BASE + k] = timer_chan_out[k];
      end
    // Interrupt inputs on pins 15 and 14
    alt_sel[15]  = alt_sel[15] | ext_interrupt_five_en;
    alt_free[15] = ext_interrupt_five_en;                               // RULE_03
    alt_sel[14]  = alt_sel[14] | ext_interrupt_four_en;
    alt_free[14] = ext_interrupt_four_en;                               // RULE_03
    // Serial receive inputs
    alt_sel[8]  = upper_q[`PGF_U_PIN8];                   // RULE_10
    alt_free[8] = upper_q[`PGF_U_PIN8];                   // RULE_03
    alt_sel[6]  = lower_q[`PGF_L_PIN6];                   // RULE_11
    alt_free[6] = lower_q[`PGF_L_PIN6];                   // RULE_03
    alt_sel[3]  = lower_q[`PGF_L_PIN3];                   // RULE_13
    alt_free[3] = lower_q[`PGF_L_PIN3];                   // RULE_03
    // Serial transmit outputs drive whatever the direction
    alt_sel[7]  = lower_q[`PGF_L_PIN7];                   // RULE_11
    alt_free[7] = lower_q[`PGF_L_PIN7];                   // RULE_03
    alt_drv[7]  = 1'b1;
    alt_dat[7]  = serial2_transmit;
    alt_sel[5]  = lower_q[`PGF_L_PIN5];                   // RULE_11
    alt_free[5] = lower_q[`PGF_L_PIN5];                   // RULE_03
    alt_drv[5]  = 1'b1;
    alt_dat[5]  = serial1_transmit;
    alt_sel[2]  = lower_q[`PGF_L_PIN2];                   // RULE_13
    alt_free[2] = lower_q[`PGF_L_PIN2];                   // RULE_03
    alt_drv[2]  = 1'b1;
    alt_dat[2]  = serial0_transmit;
    // Serial clocks keep the direction bit
    alt_sel[4]  = lower_q[`PGF_L_PIN4];                   // RULE_12
    alt_dat[4]  = serial1_clock_out;
    alt_sel[1]  = lower_q[`PGF_L_PIN1];                   // RULE_12
    alt_dat[1]  = serial0_clock_out;
    // Pin 0: trigger input or interrupt output
    case (code0)
      `PGF_CODE_ALT1:
      begin
        adc_en      = 1'b1;                               // RULE_14
        alt_sel[0]  = 1'b1;
        alt_free[0] = 1'b1;                               // RULE_03
      end
      `PGF_CODE_ALT2:
      begin
        alt_sel[0]  = 1'b1;                               // RULE_14
        alt_free[0] = 1'b1;                               // RULE_03
        alt_drv[0]  = 1'b1;
        alt_dat[0]  = irq_level;
      end
      default: ;                                          // RULE_19
    endcase
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Registered so the pads never see decode glitches
  for (genvar i = 0; i < 16; i++)
  begin : g_pin
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pin_out[i]  <= 1'b0;
        pin_oe_n[i] <= 1'b1;
      end
      else
      begin
        pin_out[i]  <= alt_sel[i] ? alt_dat[i] : gpio_out[i];
        pin_oe_n[i] <= alt_free[i] ? ~alt_drv[i]   // RULE_03
                                   : ~dir_q[i];    // RULE_02
      end
    end
  end

  // ****************************************************************
  // Peripheral inputs
  // ****************************************************************
  // Deselected inputs idle high, timers and clocks idle low
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gpio_in            <= '0;
      ext_interrupt_five <= 1'b1;
      ext_interrupt_four <= 1'b1;
      serial2_receive    <= 1'b1;
      serial1_receive    <= 1'b1;
      serial0_receive    <= 1'b1;
      adc_trigger_input  <= 1'b1;
    end
    else
    begin
      gpio_in            <= pin_s;
      ext_interrupt_five <= ~ext_interrupt_five_en | pin_s[15];         // RULE_07
      ext_interrupt_four <= ~ext_interrupt_four_en | pin_s[14];         // RULE_08
      serial2_receive    <= ~alt_sel[8] | pin_s[8];       // RULE_10
      serial1_receive    <= ~alt_sel[6] | pin_s[6];       // RULE_11
      serial0_receive    <= ~alt_sel[3] | pin_s[3];       // RULE_13
      adc_trigger_input  <= ~adc_en | pin_s[0];           // RULE_14
    end
  end

  // Direction-steered inputs only listen while set as input
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_chan_in    <= '0;
      serial1_clock_in <= 1'b0;
      serial0_clock_in <= 1'b0;
    end
    else
    begin
      timer_chan_in    <= tmr_en & ~dir_q[15:9] & pin_s[15:9]; // RULE_02
      serial1_clock_in <= alt_sel[4] & ~dir_q[4] & pin_s[4];   // RULE_12
      serial0_clock_in <= alt_sel[1] & ~dir_q[1] & pin_s[1];   // RULE_12
    end
  end

  // ****************************************************************
  // Clock output pin
  // ****************************************************************
  // Half-rate copy keeps the output on a flop; limits the rate
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      clock_pin_out <= 1'b0;
    else if (cko_q[`PGF_CKO_LOW])
      clock_pin_out <= 1'b0;                              // RULE_17
    else
      clock_pin_out <= ~clock_pin_out;                    // RULE_17
  end

endmodule : pgf_pin_mux

// [test/pgf_pin_mux_properties.sv]
`timescale 1ns/1ns
`include "pgf_consts.svh"

// ********************
// Port checks of the pin function block
// ********************
module pgf_pin_mux_properties
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // Register bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Clock pin
  input wire logic              clock_pin_out
);
  logic mapped;

  // Decode of the four word offsets
  assign mapped = paddr == ADDR_W'(`PGF_OFS_DIR) ||
                  paddr == ADDR_W'(`PGF_OFS_UPPER) ||
                  paddr == ADDR_W'(`PGF_OFS_LOWER) ||
                  paddr == ADDR_W'(`PGF_OFS_CKO);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("answer not after exactly one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  chk_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside the answer cycle");
  chk_high_half: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper half of read data not zero");
  chk_err_unmapped: assert property (
    pready && !mapped |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  chk_no_error: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  chk_rsvd_upper: assert property (
    pready && !pwrite && paddr == ADDR_W'(`PGF_OFS_UPPER) |->
    (prdata[15:0] | `PGF_WMASK_UPPER) == 16'hFFFF)
    else $error("reserved upper bit read as zero");
  chk_rsvd_lower: assert property (
    pready && !pwrite && paddr == ADDR_W'(`PGF_OFS_LOWER) |->
    (prdata[15:0] | `PGF_WMASK_LOWER) == 16'hFFFF)
    else $error("reserved lower bit read as zero");
  chk_rsvd_clock: assert property (
    pready && !pwrite && paddr == ADDR_W'(`PGF_OFS_CKO) |->
    (prdata[15:0] | `PGF_WMASK_CKO) == 16'hFFFF)
    else $error("reserved clock control bit read as zero");
  chk_clk_toggle: assert property (clock_pin_out |=> !clock_pin_out)
    else $error("clock pin high for two cycles");
endmodule : pgf_pin_mux_properties

bind pgf_pin_mux pgf_pin_mux_properties #(.ADDR_W(ADDR_W)) u_props (
  .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .clock_pin_out
);

// [test/pgf_pad_model.sv]
`timescale 1ns/1ns

// ********************
// Pads and outside circuitry
// ********************
module pgf_pad_model
(
  // Pad side of the block
  input wire pgf_pkg::pgf_word_t pin_out,
  input wire pgf_pkg::pgf_word_t pin_oe_n,
  // Outside level on released pads
  input wire pgf_pkg::pgf_word_t ext_level,
  output pgf_pkg::pgf_word_t     pad
);
  import pgf_pkg::*;

  // Released pad never keeps the old level, the outside pattern wins
  assign pad = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : pgf_pad_model

// [test/tb_pgf_pin_mux.sv]
`timescale 1ns/1ns
`include "pgf_consts.svh"

module tb_pgf_pin_mux;
  import pgf_pkg::*;
  // ********************
  // Stimulus and observation
  // ********************
  logic        core_clk = 1'b0, rst_n = 1'b0, hw_standby = 1'b0;
  logic        wdt_por = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, rerr, clock_pin_out;
  pgf_word_t   pin_in, pin_out, pin_oe_n, gpio_in;
  pgf_word_t   gpio_out = 16'h0000, ext_level = 16'h0000;
  pgf_tmr_t    timer_chan_out = 7'h00, timer_chan_in;
  logic        ext_interrupt_five, ext_interrupt_four, adc_trigger_input;
  logic        serial2_receive, serial1_receive, serial0_receive;
  logic        serial1_clock_in, serial0_clock_in;
  logic        serial2_transmit = 1'b0, serial1_transmit = 1'b0;
  logic        serial0_transmit = 1'b0, serial1_clock_out = 1'b0;
  logic        serial0_clock_out = 1'b0, interrupt_controller_req = 1'b0;
  integer      seed = 32'hc1c091c1;
  int          n_mismatch = 0;
  int          total_checks = 0;
  logic [7:0]  ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
  logic [15:0] rstv [4] = '{16'h0000, 16'h0AAA, 16'hAA80, 16'hFFFE};

  // Free running core clock
  always #5 core_clk = ~core_clk;

  pgf_pin_mux #(.ADDR_W(8)) dut (
    .core_clk, .rst_n, .hw_standby, .wdt_por, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out,
    .pin_oe_n, .clock_pin_out, .gpio_out, .gpio_in, .ext_interrupt_five,
    .ext_interrupt_four, .timer_chan_out, .timer_chan_in, .serial2_receive,
    .serial2_transmit, .serial1_receive, .serial1_transmit,
    .serial1_clock_out, .serial1_clock_in, .serial0_receive,
    .serial0_transmit, .serial0_clock_out, .serial0_clock_in,
    .adc_trigger_input, .interrupt_controller_req
  );
  pgf_pad_model pads (.pin_out, .pin_oe_n, .ext_level, .pad(pin_in));

  // ********************
  // Helpers
  // ********************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // One transfer; the request holds until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= {2'b00, w, w};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", rdat, {16'h0000, e});
  endtask : rd_chk

  // New random levels on every peripheral and outside source
  task automatic shake;
    gpio_out       <= 16'($random(seed));
    ext_level      <= 16'($random(seed));
    timer_chan_out <= 7'($random(seed));
    {serial2_transmit, serial1_transmit, serial0_transmit, serial1_clock_out,
     serial0_clock_out, interrupt_controller_req} <= 6'($random(seed));
  endtask : shake

  // Reserved bits come back as ones whatever was written
  function automatic logic [15:0] exp_rd(input int k, input logic [15:0] v);
    case (k)
      1: return v | ~`PGF_WMASK_UPPER;
      2: return v | ~`PGF_WMASK_LOWER;
      3: return v | ~`PGF_WMASK_CKO;
      default: return v;
    endcase
  endfunction : exp_rd

  // ********************
  // Main sequence
  // ********************
  initial
  begin : main
    logic [15:0] d;
    logic [15:0] v;
    int          nh;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd_chk(ofs[i], rstv[i]);
    // Random values, so reserved bits are also written with zeros
    for (int i = 0; i < 16; i++)
    begin
      v = 16'($random(seed));
      wr(ofs[i % 4], v);
      rd_chk(ofs[i % 4], exp_rd(i % 4, v));
    end
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped data", rdat, 32'h0);
    chk("unmapped error", rerr, 32'h1);
    $display("test registers done");
    wr(ofs[1], 16'h0AAA);
    wr(ofs[2], 16'hAA80);
    repeat (6)
    begin
      d = 16'($random(seed));
      wr(ofs[0], d);
      shake();
      tick(5);
      chk("oe_n", pin_oe_n, 16'(~d));
      chk("gpio out", pin_out & d, gpio_out & d);
      chk("gpio in", gpio_in, (gpio_out & d) | (ext_level & ~d));
      chk("idle ins", {ext_interrupt_five, ext_interrupt_four, serial2_receive,
          serial1_receive, serial0_receive, adc_trigger_input},
          6'h3F);
    end
    $display("test general io done");
    for (int k = 0; k < 2; k++)
    begin
      d = {16{k[0]}};
      wr(ofs[0], d);
      wr(ofs[1], 16'h57FF);
      wr(ofs[2], 16'hFFF5);
      shake();
      tick(5);
      chk("oe_n", pin_oe_n, 16'hC149 | (~d & 16'h3E12));
      chk("inputs", {ext_interrupt_five, ext_interrupt_four, serial2_receive,
          serial1_receive, serial0_receive, adc_trigger_input},
          {ext_level[15:14], ext_level[8], ext_level[6], ext_level[3],
          ext_level[0]});
      chk("transmit", {pin_out[7], pin_out[5], pin_out[2]}, {serial2_transmit,
          serial1_transmit, serial0_transmit});
      if (k == 1)
        chk("drive", {pin_out[13:9], pin_out[4], pin_out[1]},
            {timer_chan_out[4:0], serial1_clock_out,
            serial0_clock_out});
      else
        chk("capture", {timer_chan_in[4:0], serial1_clock_in,
            serial0_clock_in}, {ext_level[13:9], ext_level[4],
            ext_level[1]});
      wr(ofs[1], 16'hA7FF);
      tick(5);
      chk("timer five", k ? pin_out[15:14] : timer_chan_in[6:5],
          k ? timer_chan_out[6:5] : ext_level[15:14]);
      wr(ofs[1], 16'hFFFF);
      tick(5);
      chk("reserved code", {pin_oe_n[15:14], pin_out[15:14] & d[15:14],
          ext_interrupt_five}, {~d[15:14], gpio_out[15:14] & d[15:14],
          1'b1});
    end
    // Interrupt output modes on pin 0; the reserved mode must hold the pin high
    for (int i = 0; i < 3; i++)
    begin
      wr(ofs[2], 16'hFFF8 | 16'(i == 0) | (16'(i == 2) << 1));
      shake();
      tick(5);
      chk("irq pin", {pin_oe_n[0], pin_out[0]}, {1'b0, (i == 0) ?
          ~interrupt_controller_req : 1'b1});
    end
    $display("test functions done");
    for (int k = 0; k < 2; k++)
    begin
      wr(ofs[3], 16'hFFFE | 16'(k == 0));
      tick(2);
      nh = 0;
      repeat (8)
      begin
        @(posedge core_clk);
        nh += int'(clock_pin_out === 1'b1);
      end
      chk("clock highs", nh, k * 4);
    end
    wr(ofs[0], 16'h5A5A);
    wr(ofs[3], 16'hFFFF);
    wdt_por <= 1'b1;
    tick(1);
    wdt_por <= 1'b0;
    rd_chk(ofs[0], 16'h5A5A);
    rd_chk(ofs[3], 16'hFFFE);
    // Standby with a write inside that must be dropped
    hw_standby <= 1'b1;
    tick(4);
    wr(ofs[0], 16'hFFFF);
    hw_standby <= 1'b0;
    tick(3);
    for (int i = 0; i < 4; i++)
      rd_chk(ofs[i], rstv[i]);
    $display("test clock and standby done");
    complete_run();
  end : main
endmodule : tb_pgf_pin_mux
